// >>> common/mfp_pkg.sv
// Package of the measurement frame packer: field layouts, header words and carriers.
// Assumes one clock domain; shared by the packer and its test bench.
package mfp_pkg;

    // ****************************************
    // Word and header layout
    // ****************************************
    localparam int          WORD_W        = 32;
    localparam int          BYTE_W        = 8;
    localparam int          BYTES_PER_W   = WORD_W / BYTE_W;
    localparam logic [31:0] HDR_PREAMBLE  = 32'h41544144;
    localparam logic [31:0] HDR_FFT_LEN   = 32'h0000_0000;
    localparam logic [3:0]  HDR_WORDS     = 4'h7;
    localparam logic [3:0]  HDR_IDX_PRE   = 4'h0;
    localparam logic [3:0]  HDR_IDX_ORDER = 4'h1;
    localparam logic [3:0]  HDR_IDX_SER   = 4'h2;
    localparam logic [3:0]  HDR_IDX_FFT   = 4'h3;
    localparam logic [3:0]  HDR_IDX_LEN   = 4'h4;
    localparam logic [3:0]  HDR_IDX_FRMS  = 4'h5;
    localparam logic [3:0]  HDR_IDX_CNT   = 4'h6;

    // ****************************************
    // Frame field order, one select bit each
    // ****************************************
    localparam int          NUM_FIELDS    = 9;
    localparam logic [3:0]  F_MAG         = 4'h0;
    localparam logic [3:0]  F_EXPO        = 4'h1;
    localparam logic [3:0]  F_ENC1        = 4'h2;
    localparam logic [3:0]  F_ENC2        = 4'h3;
    localparam logic [3:0]  F_DISP        = 4'h4;
    localparam logic [3:0]  F_RATE        = 4'h5;
    localparam logic [3:0]  F_TSTAMP      = 4'h6;
    localparam logic [3:0]  F_COUNT       = 4'h7;
    localparam logic [3:0]  F_STATE       = 4'h8;
    localparam logic [3:0]  F_LAST        = 4'h8;

    // ****************************************
    // Signal quality word layout
    // ****************************************
    localparam int          QP_W          = 11;
    localparam int          QM_W          = 14;
    localparam int          QRSV_LO_W     = 5;
    localparam int          QRSV_HI_W     = 2;

    // Output buffer depth.
    localparam int          BUF_DEPTH     = 2;

    // One sample of all measurement values.
    typedef struct packed {
        logic        [31:0]     magnitude_spectrum_field;
        logic        [31:0]     exposure_time_field;   // 100 ns per count.
        logic        [31:0]     first_encoder_field;
        logic        [31:0]     second_encoder_field;
        logic signed [31:0]     displacement_field;    // 10 pm per count.
        logic        [QP_W-1:0] peak_quality;          // 2048 is 100 percent.
        logic        [QM_W-1:0] peak_maximum;
        logic        [31:0]     sample_rate_field;
        logic        [31:0]     time_stamp;            // 1 us per count.
        logic        [31:0]     value_counter;
        logic        [31:0]     state_word;
    } mfp_sample_type;

    // Output selection: one bit per field plus the quality word.
    typedef struct packed {
        logic [NUM_FIELDS-1:0] fields;
        logic                  quality;
    } mfp_select_type;

    // One buffered word with its packet start marker.
    typedef struct packed {
        logic              sop;
        logic [WORD_W-1:0] data;
    } mfp_word_type;

endpackage : mfp_pkg

// >>> tb/mfp_packer_monitor.sv
// Checker of the frame packer: byte stream framing and sample handshake.
// Assumes it is bound to mfp_packer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module mfp_packer_monitor
    import mfp_pkg::*;
(
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire mfp_sample_type sample_i,
    input  wire logic           sample_valid_i,
    input  wire logic           sample_ready_o,
    input  wire mfp_select_type select_i,
    input  wire logic [7:0]     byte_o,
    input  wire logic           byte_sop_o,
    input  wire logic           byte_valid_o,
    input  wire logic           byte_ready_i
);
    // ****************************************
    // Helper state and assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic           acc, take, chg;
    logic           seen_reg, seen_next, have_reg, have_next, pend_reg, pend_next;
    logic [7:0]     idx_reg, idx_next;
    logic [15:0]    wait_reg, wait_next;
    mfp_select_type sel_reg, sel_next;
    logic [31:0]    rate_reg, rate_next;
    // Counts bytes since the last header start and times a header that is due.
    always_comb begin
        acc = byte_valid_o && byte_ready_i;
        take = sample_valid_i && sample_ready_o;
        chg = take && (!have_reg || select_i != sel_reg || sample_i.sample_rate_field != rate_reg);
        seen_next = seen_reg || acc;
        have_next = have_reg || take;
        sel_next = take ? select_i : sel_reg;
        rate_next = take ? sample_i.sample_rate_field : rate_reg;
        idx_next = idx_reg;
        if (acc && byte_sop_o) idx_next = 8'h01;
        else if (acc && idx_reg != 8'hff) idx_next = idx_reg + 8'h01;
        pend_next = chg || (pend_reg && !(acc && byte_sop_o));
        wait_next = pend_reg ? wait_reg + 16'h0001 : 16'h0000;
    end
    // Registers the helper state.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {seen_reg, have_reg, pend_reg, idx_reg, wait_reg} <= '0;
            sel_reg <= '0;
            rate_reg <= '0;
        end else begin
            {seen_reg, have_reg, pend_reg, idx_reg, wait_reg} <=
                {seen_next, have_next, pend_next, idx_next, wait_next};
            sel_reg <= sel_next;
            rate_reg <= rate_next;
        end
    end
    chk_stall_hold: assert property (byte_valid_o && !byte_ready_i |=>
        byte_valid_o && $stable(byte_o) && $stable(byte_sop_o)) else $error("byte changed under stall");
    chk_sop_lsb: assert property (byte_valid_o && byte_sop_o |->
        byte_o == HDR_PREAMBLE[7:0]) else $error("header start byte wrong");
    chk_hdr_bytes: assert property (byte_valid_o && !byte_sop_o && idx_reg inside {1, 2, 3}
        |-> byte_o == HDR_PREAMBLE[8*idx_reg +: 8]) else $error("preamble byte order wrong");
    chk_first_sop: assert property (byte_valid_o && !seen_reg |-> byte_sop_o)
        else $error("first byte is not a header start");
    chk_sop_spacing: assert property (byte_valid_o && byte_sop_o && seen_reg
        |-> idx_reg >= 8'h1c) else $error("header start inside a header");
    chk_take_drops: assert property (take |=> !sample_ready_o)
        else $error("ready stayed high after take");
    chk_ready_waits: assert property (sample_ready_o && !sample_valid_i |=> sample_ready_o)
        else $error("ready dropped without take");
    chk_header_due: assert property (pend_reg |-> wait_reg < 16'h03e8)
        else $error("header not sent after change");
    cover property (take);
    cover property (byte_valid_o && !byte_ready_i);
    cover property (chg && have_reg);
endmodule : mfp_packer_monitor
bind mfp_packer mfp_packer_monitor mfp_packer_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
    .sample_i(sample_i), .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
    .select_i(select_i), .byte_o(byte_o), .byte_sop_o(byte_sop_o),
    .byte_valid_o(byte_valid_o), .byte_ready_i(byte_ready_i));
`default_nettype wire

// >>> tb/mfp_packer_tb.sv
// Self-checking bench of the frame packer with a server model on the byte side.
// Assumes the packer, its package and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module mfp_packer_tb;
    import mfp_pkg::*;
    // ****************************************
    // Set-up, rows and tasks
    // ****************************************
    localparam logic [31:0] FPB = 32'h0000_0002;
    localparam logic [31:0] ORD = 32'h0000_00a5; // Arbitrary value.
    localparam logic [31:0] SER = 32'h0000_005a; // Arbitrary value.
    localparam logic [31:0] RA  = 32'h0000_4e20;
    localparam logic [31:0] RB  = 32'h0000_2710;
    typedef struct packed {
        logic [9:0]  sel;
        logic [31:0] rate;
        logic        hdr;
    } mfp_row_type;
    localparam mfp_row_type ROWS[8] = '{'{10'h3ff, RA, 1'b1}, '{10'h3ff, RA, 1'b0},
        '{10'h3ff, RA, 1'b1}, '{10'h010, RA, 1'b1}, '{10'h028, RA, 1'b1},
        '{10'h028, RB, 1'b1}, '{10'h1a1, RA, 1'b1}, '{10'h000, RA, 1'b1}};
    logic           clk_i = 1'b0;
    logic           rst_i = 1'b1;
    mfp_sample_type sample_i = '0;
    logic           sample_valid_i = 1'b0;
    logic           sample_ready_o, byte_sop_o, byte_valid_o, byte_ready_i;
    mfp_select_type select_i = '0;
    logic [7:0]     byte_o;
    logic           slow = 1'b0;
    logic [32:0]    ex[$];
    mfp_sample_type smp;
    int             n_errors = 0, checks = 0, cycles = 0, base = 0;
    always #4 clk_i = ~clk_i;
    mfp_packer #(.FRAMES_PER_BLOCK(FPB), .ORDER_NUMBER(ORD), .SERIAL_NUMBER(SER)) mfp_packer_inst (
        .clk_i(clk_i), .rst_i(rst_i), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
        .sample_ready_o(sample_ready_o), .select_i(select_i), .byte_o(byte_o),
        .byte_sop_o(byte_sop_o), .byte_valid_o(byte_valid_o), .byte_ready_i(byte_ready_i));
    mfp_sink mfp_sink_inst (.clk_i(clk_i), .rst_i(rst_i), .byte_i(byte_o), .sop_i(byte_sop_o),
        .valid_i(byte_valid_o), .slow_i(slow), .ready_o(byte_ready_i));
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    // Cuts a hung run short.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic cmp32(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : cmp32
    task automatic cmp1(input string what, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %b seen %b", what, e, g);
        end
    endtask : cmp1
    // Builds one sample whose fields are easy to tell apart; displacement is negative.
    function automatic mfp_sample_type mk(input logic [31:0] k, input logic [31:0] rate);
        mk.magnitude_spectrum_field = 32'h1100_0000 | k;
        mk.exposure_time_field = 32'h2200_0000 | k;
        mk.first_encoder_field = 32'h3300_0000 | k;
        mk.second_encoder_field = 32'hf400_0000 | k;
        mk.displacement_field = 32'hffff_ff00 | k;
        mk.peak_quality = 11'h400;
        mk.peak_maximum = 14'h3fff;
        mk.sample_rate_field = rate;
        mk.time_stamp = 32'h7700_0000 | k;
        mk.value_counter = 32'h8800_0000 | k;
        mk.state_word = 32'h9900_0000 | k;
    endfunction : mk
    // Appends the words that one sample should produce, header first when due.
    task automatic add_frame(input mfp_select_type sl, input mfp_sample_type s, input logic h,
                             input logic [31:0] cnt);
        logic [31:0] f[$];
        logic [31:0] v[9];
        v = '{s.magnitude_spectrum_field, s.exposure_time_field, s.first_encoder_field,
              s.second_encoder_field, s.displacement_field, s.sample_rate_field, s.time_stamp,
              s.value_counter, s.state_word};
        for (int i = 0; i < 9; i++) begin
            if (i == 4 && sl.fields[4] && sl.quality)
                f.push_back({2'h0, s.peak_maximum, 5'h00, s.peak_quality});
            if (sl.fields[i]) f.push_back(v[i]);
        end
        if (h) begin
            ex.push_back({1'b1, HDR_PREAMBLE});
            ex.push_back({1'b0, ORD});
            ex.push_back({1'b0, SER});
            ex.push_back({1'b0, HDR_FFT_LEN});
            ex.push_back({1'b0, 32'(f.size() * 4) * FPB});
            ex.push_back({1'b0, FPB});
            ex.push_back({1'b0, cnt});
        end
        foreach (f[i]) ex.push_back({1'b0, f[i]});
    endtask : add_frame
    task automatic send(input mfp_select_type sl, input mfp_sample_type s);
        @(posedge clk_i);
        #1 sample_i = s;
        select_i = sl;
        sample_valid_i = 1'b1;
        do @(posedge clk_i); while (sample_ready_o !== 1'b1);
        #1 sample_valid_i = 1'b0;
    endtask : send
    task automatic wait_words(input int n);
        for (int i = 0; i < 5000 && mfp_sink_inst.words.size() < base + n; i++) @(posedge clk_i);
    endtask : wait_words
    task automatic check_all(input string name);
        wait_words(ex.size());
        cmp32("word count", 32'(ex.size()), 32'(mfp_sink_inst.words.size() - base));
        for (int i = 0; i < ex.size() && base + i < mfp_sink_inst.words.size(); i++) begin
            cmp32("word", ex[i][31:0], mfp_sink_inst.words[base + i][31:0]);
            cmp1("start flag", ex[i][32], mfp_sink_inst.words[base + i][32]);
        end
        base = mfp_sink_inst.words.size();
        ex.delete();
        $display("Test %s done", name);
    endtask : check_all
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clk_i);
        #1 rst_i = 1'b0;
        @(posedge clk_i);
        // Row loop: samples go back to back, the sink stalls on odd rows.
        for (int r = 0; r < 8; r++) begin
            slow = r[0];
            smp = mk(32'(r + 1), ROWS[r].rate);
            add_frame(ROWS[r].sel, smp, ROWS[r].hdr, 32'(r + 1));
            send(ROWS[r].sel, smp);
        end
        check_all("rows");
        // Reset in mid-frame, then a fresh header and a single encoder word.
        smp = mk(32'h0000_0009, RA);
        send(10'h3ff, smp);
        wait_words(3);
        #1 rst_i = 1'b1;
        @(posedge clk_i);
        #1 cmp1("valid in reset", 1'b0, byte_valid_o);
        cmp1("ready in reset", 1'b0, sample_ready_o);
        repeat (2) @(posedge clk_i);
        #1 rst_i = 1'b0;
        base = 0;
        @(posedge clk_i);
        add_frame(10'h008, smp, 1'b1, 32'h0000_0001);
        send(10'h008, smp);
        check_all("reset");
        summarize();
    end
endmodule : mfp_packer_tb
`default_nettype wire

// >>> tb/mfp_sink.sv
// Model of the measurement value server: takes bytes and rebuilds 32-bit words.
// Assumes the packer's byte handshake; slow_i makes it accept one byte in four cycles.
`timescale 1ns/1ps
`default_nettype none
module mfp_sink (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] byte_i,
    input  wire logic       sop_i,
    input  wire logic       valid_i,
    input  wire logic       slow_i,
    output var  logic       ready_o
);
    // ****************************************
    // Byte capture
    // ****************************************
    logic [32:0] words[$];          // Bit 32 holds the start marker of the first byte.
    logic [23:0] low_reg;
    logic [1:0]  pos_reg;
    logic [1:0]  tick_reg;
    logic        sop_reg;
    // Gathers four accepted bytes, least significant first, into one word.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
            pos_reg <= 2'h0;
            tick_reg <= 2'h0;
            words.delete();
        end else begin
            tick_reg <= tick_reg + 2'h1;
            ready_o <= !slow_i || tick_reg == 2'h3;
            if (valid_i && ready_o) begin
                pos_reg <= pos_reg + 2'h1;
                if (pos_reg == 2'h0) sop_reg <= sop_i;
                if (pos_reg == 2'h3) words.push_back({sop_reg, byte_i, low_reg});
                else low_reg[8*pos_reg +: 8] <= byte_i;
            end
        end
    end
endmodule : mfp_sink
`default_nettype wire

// >>> verilog/mfp_packer.sv
// Measurement frame packer: builds header and value frames and streams them as bytes.
// Assumes synchronous sample and select inputs and a byte sink with ready back-pressure.
`timescale 1ns/1ps
`default_nettype none

module mfp_packer
    import mfp_pkg::*;
#(
    parameter int          DEPTH            = BUF_DEPTH,
    parameter logic [31:0] FRAMES_PER_BLOCK = 32'h0000_0010,
    parameter logic [31:0] ORDER_NUMBER     = 32'h0000_0001, // Arbitrary value.
    parameter logic [31:0] SERIAL_NUMBER    = 32'h0000_0002  // Arbitrary value.
) (
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire mfp_sample_type sample_i,
    input  wire logic           sample_valid_i,
    output var  logic           sample_ready_o,
    input  wire mfp_select_type select_i,
    output var  logic [7:0]     byte_o,
    output var  logic           byte_sop_o,
    output var  logic           byte_valid_o,
    input  wire logic           byte_ready_i
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HDR,
        ST_FRM
    } mfp_state_type;

    // ****************************************
    // Producer state
    // ****************************************
    mfp_state_type  state_reg,    state_next;
    logic [3:0]     idx_reg,      idx_next;
    logic           qph_reg,      qph_next;
    mfp_sample_type snap_reg,     snap_next;
    mfp_select_type sel_reg,      sel_next;
    mfp_select_type lsel_reg,     lsel_next;
    logic [31:0]    lrate_reg,    lrate_next;
    logic           hdr_ok_reg,   hdr_ok_next;
    logic [31:0]    blk_reg,      blk_next;
    logic [31:0]    proc_reg,     proc_next;
    logic           rdy_reg,      rdy_next;
    logic           prod_valid;
    mfp_word_type   prod_word;
    logic           push;
    logic           adv;
    logic           need_hdr;
    logic [31:0]    frame_bytes;
    logic [31:0]    qual_word;

    // ****************************************
    // Buffer and serializer state
    // ****************************************
    mfp_word_type   mem_reg [DEPTH];
    logic [PW-1:0]  wp_reg,       wp_next;
    logic [PW-1:0]  rp_reg,       rp_next;
    logic [CW-1:0]  cnt_reg,      cnt_next;
    logic           pop;
    logic           buf_ready;
    logic           buf_valid;
    logic [31:0]    ser_reg,      ser_next;
    logic [2:0]     left_reg,     left_next;
    logic           ssop_reg,     ssop_next;
    logic [7:0]     byte_reg,     byte_next;
    logic           bsop_reg,     bsop_next;
    logic           bval_reg,     bval_next;

    // Picks the word of one frame field from the captured sample.
    function automatic logic [31:0] field_word(input logic [3:0] f, input mfp_sample_type s);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (f)
            F_MAG:    w = s.magnitude_spectrum_field;
            F_EXPO:   w = s.exposure_time_field;
            F_ENC1:   w = s.first_encoder_field;
            F_ENC2:   w = s.second_encoder_field;
            F_DISP:   w = s.displacement_field;
            F_RATE:   w = s.sample_rate_field;
            F_TSTAMP: w = s.time_stamp;
            F_COUNT:  w = s.value_counter;
            F_STATE:  w = s.state_word;
            default:  w = 32'h0000_0000;
        endcase
        return w;
    endfunction : field_word

    // Quality word with reserved bits forced low.
    assign qual_word = {{QRSV_HI_W{1'b0}}, snap_reg.peak_maximum,
                        {QRSV_LO_W{1'b0}}, snap_reg.peak_quality};

    // Bytes in one frame, counting the quality word when sent.
    always_comb begin
        frame_bytes = 32'h0000_0000;
        for (int i = 0; i < NUM_FIELDS; i++) begin
            if (sel_reg.fields[i]) begin
                frame_bytes = frame_bytes + 32'(BYTES_PER_W);
            end
        end
        if (sel_reg.fields[F_DISP] && sel_reg.quality) begin
            frame_bytes = frame_bytes + 32'(BYTES_PER_W);
        end
    end

    // A new header is due at start, on a change, or when a block is full.
    assign need_hdr = !hdr_ok_reg || (select_i != lsel_reg)
                      || (sample_i.sample_rate_field != lrate_reg)
                      || (blk_reg >= FRAMES_PER_BLOCK);

    assign push = prod_valid && buf_ready;

    // ****************************************
    // Frame producer
    // ****************************************

    // Walks header words and selected fields, one word per accepted push.
    always_comb begin
        state_next  = state_reg;
        idx_next    = idx_reg;
        qph_next    = qph_reg;
        snap_next   = snap_reg;
        sel_next    = sel_reg;
        lsel_next   = lsel_reg;
        lrate_next  = lrate_reg;
        hdr_ok_next = hdr_ok_reg;
        blk_next    = blk_reg;
        proc_next   = proc_reg;
        prod_valid  = 1'b0;
        prod_word   = '0;
        adv         = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (sample_valid_i && rdy_reg) begin
                    snap_next = sample_i;
                    sel_next  = select_i;
                    proc_next = proc_reg + 32'h0000_0001;
                    idx_next  = 4'h0;
                    qph_next  = 1'b0;
                    if (need_hdr) begin
                        state_next  = ST_HDR;
                        lsel_next   = select_i;
                        lrate_next  = sample_i.sample_rate_field;
                        hdr_ok_next = 1'b1;
                        blk_next    = 32'h0000_0000;
                    end else begin
                        state_next = ST_FRM;
                    end
                end
            end
            ST_HDR: begin
                prod_valid    = 1'b1;
                prod_word.sop = (idx_reg == HDR_IDX_PRE);
                case (idx_reg)
                    HDR_IDX_PRE:   prod_word.data = HDR_PREAMBLE;
                    HDR_IDX_ORDER: prod_word.data = ORDER_NUMBER;
                    HDR_IDX_SER:   prod_word.data = SERIAL_NUMBER;
                    HDR_IDX_FFT:   prod_word.data = HDR_FFT_LEN;
                    HDR_IDX_LEN:   prod_word.data = 32'(frame_bytes * FRAMES_PER_BLOCK);
                    HDR_IDX_FRMS:  prod_word.data = FRAMES_PER_BLOCK;
                    HDR_IDX_CNT:   prod_word.data = proc_reg;
                    default:       prod_word.data = 32'h0000_0000;
                endcase
                if (push) begin
                    if (idx_reg == HDR_WORDS - 4'h1) begin
                        state_next = ST_FRM;
                        idx_next   = 4'h0;
                    end else begin
                        idx_next = idx_reg + 4'h1;
                    end
                end
            end
            ST_FRM: begin
                if (!sel_reg.fields[idx_reg]) begin
                    adv = 1'b1;
                end else if (idx_reg == F_DISP && sel_reg.quality && !qph_reg) begin
                    prod_valid     = 1'b1;
                    prod_word.data = qual_word;
                    if (push) begin
                        qph_next = 1'b1;
                    end
                end else begin
                    prod_valid     = 1'b1;
                    prod_word.data = field_word(idx_reg, snap_reg);
                    adv            = push;
                end
                if (adv) begin
                    qph_next = 1'b0;
                    if (idx_reg == F_LAST) begin
                        state_next = ST_IDLE;
                        blk_next   = blk_reg + 32'h0000_0001;
                    end else begin
                        idx_next = idx_reg + 4'h1;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        rdy_next = (state_next == ST_IDLE);
    end

    // Registers the producer state.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg  <= ST_IDLE;
            idx_reg    <= 4'h0;
            qph_reg    <= 1'b0;
            snap_reg   <= '0;
            sel_reg    <= '0;
            lsel_reg   <= '0;
            lrate_reg  <= 32'h0000_0000;
            hdr_ok_reg <= 1'b0;
            blk_reg    <= 32'h0000_0000;
            proc_reg   <= 32'h0000_0000;
            rdy_reg    <= 1'b0;
        end else begin
            state_reg  <= state_next;
            idx_reg    <= idx_next;
            qph_reg    <= qph_next;
            snap_reg   <= snap_next;
            sel_reg    <= sel_next;
            lsel_reg   <= lsel_next;
            lrate_reg  <= lrate_next;
            hdr_ok_reg <= hdr_ok_next;
            blk_reg    <= blk_next;
            proc_reg   <= proc_next;
            rdy_reg    <= rdy_next;
        end
    end

    // ****************************************
    // Word buffer
    // ****************************************

    assign buf_ready = (cnt_reg != CW'(DEPTH));
    assign buf_valid = (cnt_reg != '0);

    // Moves the pointers and the fill count.
    always_comb begin
        wp_next  = push ? PW'((wp_reg + 1'b1) % DEPTH) : wp_reg;
        rp_next  = pop ? PW'((rp_reg + 1'b1) % DEPTH) : rp_reg;
        cnt_next = cnt_reg + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    // One storage entry per slot, written when the write pointer selects it.
    for (genvar e = 0; e < DEPTH; e++) begin : g_entry
        mfp_word_type ent_next;

        always_comb begin
            ent_next = (push && wp_reg == PW'(e)) ? prod_word : mem_reg[e];
        end

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                mem_reg[e] <= '0;
            end else begin
                mem_reg[e] <= ent_next;
            end
        end
    end

    // ****************************************
    // Byte serializer
    // ****************************************

    assign pop = buf_valid && (left_reg == 3'h0);

    // Loads a word when empty and sends it low byte first.
    always_comb begin
        ser_next  = ser_reg;
        left_next = left_reg;
        ssop_next = ssop_reg;
        byte_next = byte_reg;
        bsop_next = bsop_reg;
        bval_next = bval_reg;
        if (pop) begin
            ser_next  = mem_reg[rp_reg].data;
            ssop_next = mem_reg[rp_reg].sop;
            left_next = 3'(BYTES_PER_W);
            bval_next = bval_reg && !byte_ready_i;  // A byte taken at this edge must not repeat.
        end else if (!bval_reg || byte_ready_i) begin
            if (left_reg != 3'h0) begin
                byte_next = ser_reg[7:0];
                bsop_next = ssop_reg && (left_reg == 3'(BYTES_PER_W));
                bval_next = 1'b1;
                ser_next  = {8'h00, ser_reg[31:8]};
                left_next = left_reg - 3'h1;
            end else begin
                bval_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ser_reg  <= 32'h0000_0000;
            left_reg <= 3'h0;
            ssop_reg <= 1'b0;
            byte_reg <= 8'h00;
            bsop_reg <= 1'b0;
            bval_reg <= 1'b0;
        end else begin
            ser_reg  <= ser_next;
            left_reg <= left_next;
            ssop_reg <= ssop_next;
            byte_reg <= byte_next;
            bsop_reg <= bsop_next;
            bval_reg <= bval_next;
        end
    end

    // Outputs straight from flip-flops.
    assign sample_ready_o = rdy_reg;
    assign byte_o         = byte_reg;
    assign byte_sop_o     = bsop_reg;
    assign byte_valid_o   = bval_reg;

endmodule : mfp_packer

`default_nettype wire
